// ### rtl/ce_edge_detect.sv
// Edge detector that turns the comparator level into selected events
`timescale 1ns/1ps
module ce_edge_detect (
   input wire logic core_clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic level, // Synchronised comparator result
   input wire logic [1:0] mode, // Event mode select
   output logic event_pulse // One-cycle event
);

   logic prev_reg;
   logic rise;
   logic fall;

   // Previous value of the level, one clock back
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         prev_reg <= 1'b0;
      else
         prev_reg <= level;
   end

   assign rise = level & ~prev_reg;
   assign fall = ~level & prev_reg;

   // Mode decode; the reserved code never produces an event
   always_comb
   begin
      case (mode)
         ce_pkg::MODE_TOGGLE: event_pulse = rise | fall;
         ce_pkg::MODE_FALLING: event_pulse = fall;
         ce_pkg::MODE_RISING: event_pulse = rise;
         ce_pkg::MODE_RESERVED: event_pulse = 1'b0;
         default: event_pulse = 1'b0;
      endcase
   end

endmodule

// ### rtl/ce_event_ctrl.sv
// Comparator event control: input select, sync, events, capture route
//
// Contract
// - Result high when positive input exceeds negative
// - Result synchronised, lagging one to two clocks
// - Borrow with converter off picks channel input
// - Bandgap select replaces positive pin input
// - Disable bit powers comparator down anytime
// - Selected transition sets the event flag
// - Flag clears on vector or written one
// - Interrupt needs flag, enable, global enable
// - Modes: toggle, reserved, falling, rising
// - Capture route feeds timer capture front end
// - Input-off bit kills buffer, pin reads zero
`timescale 1ns/1ps
module ce_event_ctrl #(
   parameter int unsigned SYNC_STAGES = ce_pkg::SYNC_STAGES
) (
   input wire logic core_clk, // System clock, 50 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [7:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall until answer
   input wire logic comparator_raw, // Analog core decision, async
   output logic comparator_power_down, // Power off the analog core
   output logic positive_bandgap_select, // Bandgap to positive input
   output logic negative_mux_select, // Converter mux to negative input
   output logic [2:0] negative_channel, // Channel for negative input
   input wire logic converter_enable, // Converter enable, same clock
   input wire logic [2:0] channel_select, // Converter channel bits
   input wire logic global_irq_enable, // CPU global enable
   input wire logic irq_vector_taken, // Vector fetch pulse
   output logic comparator_irq, // Interrupt request
   output logic capture_trigger, // To timer capture front end
   input wire logic positive_pin_raw, // Positive pin, async
   input wire logic negative_pin_raw, // Negative pin, async
   output logic positive_pin_input_off, // Positive pin buffer off
   output logic negative_pin_input_off, // Negative pin buffer off
   output logic positive_pin_read, // Positive pin read bit
   output logic negative_pin_read // Negative pin read bit
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic comparator_disable_reg;
   logic bandgap_select_reg;
   logic comparator_event_flag_reg;
   logic comparator_event_flag_next;
   logic comparator_irq_enable_reg;
   logic capture_route_enable_reg;
   logic event_mode_high_reg;
   logic event_mode_low_reg;
   logic mux_borrow_enable_reg;
   logic positive_pin_input_off_reg;
   logic negative_pin_input_off_reg;
   logic comparator_power_down_reg;
   logic positive_bandgap_select_reg;
   logic negative_mux_select_reg;
   logic [2:0] negative_channel_reg;
   logic comparator_irq_reg;
   logic capture_trigger_reg;
   logic positive_pin_read_reg;
   logic negative_pin_read_reg;
   logic [31:0] avs_readdata_reg;
   logic avs_waitrequest_reg;
   logic raw_sync;
   logic comparator_result;
   logic [1:0] pin_sync;
   logic event_pulse;
   logic take;
   logic wr_ok;
   logic flag_clear_write;
   logic [7:0] ctrl_status_view;
   logic [31:0] read_view;

   // Synchroniser shorter than two stages is refused at elaboration
   if (SYNC_STAGES < 2)
   begin
      $error("ce_event_ctrl: SYNC_STAGES must be at least 2");
   end

   // ----------------------------------------------------------------
   // Comparator output synchronisation and edge events
   // ----------------------------------------------------------------
   ce_sync #(
      .WIDTH(1),
      .STAGES(SYNC_STAGES)
   ) u_result_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(comparator_raw),
      .sync_out(raw_sync)
   );

   // The analog core decides pos > neg; the disable bit forces the result low
   assign comparator_result = raw_sync & ~comparator_disable_reg;

   ce_edge_detect u_edge (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .level(comparator_result),
      .mode({event_mode_high_reg, event_mode_low_reg}),
      .event_pulse(event_pulse)
   );

   // ----------------------------------------------------------------
   // Bus slave: one wait cycle, then answer for one cycle
   // ----------------------------------------------------------------
   assign take = (avs_read | avs_write) & avs_waitrequest_reg;
   assign wr_ok = avs_write & ~avs_waitrequest_reg & avs_byteenable[0];

   // Waitrequest drops for exactly the answering cycle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         avs_waitrequest_reg <= 1'b1;
      else if (take)
         avs_waitrequest_reg <= 1'b0;
      else
         avs_waitrequest_reg <= 1'b1;
   end

   // Status view with the live result bit
   assign ctrl_status_view = {comparator_disable_reg, bandgap_select_reg, comparator_result,
                              comparator_event_flag_reg, comparator_irq_enable_reg,
                              capture_route_enable_reg, event_mode_high_reg,
                              event_mode_low_reg};

   // Read mux; unmapped addresses read as zero
   always_comb
   begin
      read_view = 32'h00000000;
      case (avs_address)
         ce_pkg::CTRL_STATUS_OFFSET: read_view[7:0] = ctrl_status_view;
         ce_pkg::CTRL_B_OFFSET: read_view[ce_pkg::MUX_BORROW_BIT] = mux_borrow_enable_reg;
         ce_pkg::INPUT_OFF_OFFSET:
         begin
            read_view[ce_pkg::NEG_OFF_BIT] = negative_pin_input_off_reg;
            read_view[ce_pkg::POS_OFF_BIT] = positive_pin_input_off_reg;
         end
         default: read_view = 32'h00000000;
      endcase
   end

   // Read data captured with the answer so it stands at the sampling edge
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         avs_readdata_reg <= 32'h00000000;
      else if (take && avs_read)
         avs_readdata_reg <= read_view;
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Control and status fields; the result bit is read only
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         comparator_disable_reg <= ce_pkg::CTRL_STATUS_RESET[ce_pkg::DISABLE_BIT];
         bandgap_select_reg <= ce_pkg::CTRL_STATUS_RESET[ce_pkg::BANDGAP_BIT];
         comparator_irq_enable_reg <= ce_pkg::CTRL_STATUS_RESET[ce_pkg::IRQ_EN_BIT];
         capture_route_enable_reg <= ce_pkg::CTRL_STATUS_RESET[ce_pkg::CAPTURE_BIT];
         event_mode_high_reg <= ce_pkg::CTRL_STATUS_RESET[ce_pkg::MODE_HIGH_BIT];
         event_mode_low_reg <= ce_pkg::CTRL_STATUS_RESET[ce_pkg::MODE_LOW_BIT];
      end
      else if (wr_ok && avs_address == ce_pkg::CTRL_STATUS_OFFSET)
      begin
         // No guard against mode changes with the interrupt on: software's duty
         comparator_disable_reg <= avs_writedata[ce_pkg::DISABLE_BIT];
         bandgap_select_reg <= avs_writedata[ce_pkg::BANDGAP_BIT];
         comparator_irq_enable_reg <= avs_writedata[ce_pkg::IRQ_EN_BIT];
         capture_route_enable_reg <= avs_writedata[ce_pkg::CAPTURE_BIT];
         event_mode_high_reg <= avs_writedata[ce_pkg::MODE_HIGH_BIT];
         event_mode_low_reg <= avs_writedata[ce_pkg::MODE_LOW_BIT];
      end
   end

   // Multiplexer borrow and pin input-off registers
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         mux_borrow_enable_reg <= ce_pkg::CTRL_B_RESET[ce_pkg::MUX_BORROW_BIT];
         positive_pin_input_off_reg <= ce_pkg::INPUT_OFF_RESET[ce_pkg::POS_OFF_BIT];
         negative_pin_input_off_reg <= ce_pkg::INPUT_OFF_RESET[ce_pkg::NEG_OFF_BIT];
      end
      else if (wr_ok && avs_address == ce_pkg::CTRL_B_OFFSET)
         mux_borrow_enable_reg <= avs_writedata[ce_pkg::MUX_BORROW_BIT];
      else if (wr_ok && avs_address == ce_pkg::INPUT_OFF_OFFSET)
      begin
         positive_pin_input_off_reg <= avs_writedata[ce_pkg::POS_OFF_BIT];
         negative_pin_input_off_reg <= avs_writedata[ce_pkg::NEG_OFF_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Event flag and interrupt request
   // ----------------------------------------------------------------
   assign flag_clear_write = wr_ok && avs_address == ce_pkg::CTRL_STATUS_OFFSET
                             && avs_writedata[ce_pkg::FLAG_BIT];

   // A new event wins over a clear in the same cycle
   assign comparator_event_flag_next = event_pulse
      | (comparator_event_flag_reg & ~(flag_clear_write | irq_vector_taken));

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         comparator_event_flag_reg <= ce_pkg::CTRL_STATUS_RESET[ce_pkg::FLAG_BIT];
      else
         comparator_event_flag_reg <= comparator_event_flag_next;
   end

   // Request only in the cycle after all three conditions hold
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         comparator_irq_reg <= 1'b0;
      else
         comparator_irq_reg <= comparator_event_flag_reg & comparator_irq_enable_reg
                               & global_irq_enable;
   end

   // ----------------------------------------------------------------
   // Analog input selection and power
   // ----------------------------------------------------------------
   // Converter must be off to lend its mux; power reduction is software's
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         comparator_power_down_reg <= 1'b0;
         positive_bandgap_select_reg <= 1'b0;
         negative_mux_select_reg <= 1'b0;
         negative_channel_reg <= 3'h0;
      end
      else
      begin
         comparator_power_down_reg <= comparator_disable_reg;
         positive_bandgap_select_reg <= bandgap_select_reg;
         negative_mux_select_reg <= mux_borrow_enable_reg & ~converter_enable;
         negative_channel_reg <= channel_select;
      end
   end

   // ----------------------------------------------------------------
   // Timer capture route
   // ----------------------------------------------------------------
   // Timer's own canceler and edge select filter this level
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         capture_trigger_reg <= 1'b0;
      else
         capture_trigger_reg <= capture_route_enable_reg & comparator_result;
   end

   // ----------------------------------------------------------------
   // Pin digital inputs
   // ----------------------------------------------------------------
   ce_sync #(
      .WIDTH(2),
      .STAGES(SYNC_STAGES)
   ) u_pin_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in({negative_pin_raw, positive_pin_raw}),
      .sync_out(pin_sync)
   );

   // Disabled buffer reads as zero
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         positive_pin_read_reg <= 1'b0;
         negative_pin_read_reg <= 1'b0;
      end
      else
      begin
         positive_pin_read_reg <= pin_sync[0] & ~positive_pin_input_off_reg;
         negative_pin_read_reg <= pin_sync[1] & ~negative_pin_input_off_reg;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata = avs_readdata_reg;
   assign avs_waitrequest = avs_waitrequest_reg;
   assign comparator_power_down = comparator_power_down_reg;
   assign positive_bandgap_select = positive_bandgap_select_reg;
   assign negative_mux_select = negative_mux_select_reg;
   assign negative_channel = negative_channel_reg;
   assign comparator_irq = comparator_irq_reg;
   assign capture_trigger = capture_trigger_reg;
   assign positive_pin_input_off = positive_pin_input_off_reg;
   assign negative_pin_input_off = negative_pin_input_off_reg;
   assign positive_pin_read = positive_pin_read_reg;
   assign negative_pin_read = negative_pin_read_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // The chain must have left reset two edges back before it shows raw
   result_lag_a: assert property (
      $stable(comparator_raw)[*3] ##0 (!comparator_disable_reg
      && !$past(sys_rst) && !$past(sys_rst, 2))
      |-> comparator_result == comparator_raw)
      else $error("result does not follow steady raw input");

   result_off_a: assert property (
      comparator_disable_reg |-> !comparator_result)
      else $error("result high while comparator disabled");

   mux_borrow_a: assert property (
      mux_borrow_enable_reg && !converter_enable |=> negative_mux_select)
      else $error("converter mux not lent while converter off");

   mux_busy_a: assert property (
      converter_enable |=> !negative_mux_select)
      else $error("converter mux lent while converter on");

   bandgap_route_a: assert property (
      $rose(bandgap_select_reg) |=> positive_bandgap_select)
      else $error("bandgap not routed after select");

   power_down_a: assert property (
      wr_ok && avs_address == ce_pkg::CTRL_STATUS_OFFSET
      && avs_writedata[ce_pkg::DISABLE_BIT]
      |=> ##1 comparator_power_down)
      else $error("comparator not powered down after disable write");

   rising_event_a: assert property (
      {event_mode_high_reg, event_mode_low_reg} == 2'h3 && $rose(comparator_result)
      |=> comparator_event_flag_reg)
      else $error("rising edge did not set flag");

   reserved_mode_a: assert property (
      {event_mode_high_reg, event_mode_low_reg} == 2'h1 && !comparator_event_flag_reg
      |=> !comparator_event_flag_reg)
      else $error("reserved mode set the flag");

   flag_clear_a: assert property (
      comparator_event_flag_reg && irq_vector_taken && !event_pulse
      |=> !comparator_event_flag_reg)
      else $error("flag not cleared by vector");

   irq_gate_a: assert property (
      comparator_irq |-> $past(comparator_event_flag_reg)
      && $past(comparator_irq_enable_reg) && $past(global_irq_enable))
      else $error("interrupt without flag and enables");

   capture_off_a: assert property (
      !capture_route_enable_reg |=> !capture_trigger)
      else $error("capture trigger with route off");

   pin_off_a: assert property (
      positive_pin_input_off_reg |=> !positive_pin_read)
      else $error("disabled pin read nonzero");

   bus_answer_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");

   rise_seen_c: cover property (
      {event_mode_high_reg, event_mode_low_reg} == 2'h3 && event_pulse);
   toggle_seen_c: cover property (
      {event_mode_high_reg, event_mode_low_reg} == 2'h0 && event_pulse);
   irq_seen_c: cover property (comparator_irq ##1 irq_vector_taken);
   borrow_seen_c: cover property (negative_mux_select && capture_trigger);

endmodule

// ### rtl/ce_pkg.sv
// Shared constants for the comparator event control block
package ce_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h30;
   localparam logic [7:0] CTRL_B_OFFSET = 8'h34;
   localparam logic [7:0] INPUT_OFF_OFFSET = 8'h38;

   // ----------------------------------------------------------------
   // Field positions of comparator_control_status
   // ----------------------------------------------------------------
   localparam int unsigned DISABLE_BIT = 7;
   localparam int unsigned BANDGAP_BIT = 6;
   localparam int unsigned RESULT_BIT = 5;
   localparam int unsigned FLAG_BIT = 4;
   localparam int unsigned IRQ_EN_BIT = 3;
   localparam int unsigned CAPTURE_BIT = 2;
   localparam int unsigned MODE_HIGH_BIT = 1;
   localparam int unsigned MODE_LOW_BIT = 0;

   // Field positions of converter_control_b and digital_input_disable_1
   localparam int unsigned MUX_BORROW_BIT = 6;
   localparam int unsigned NEG_OFF_BIT = 1;
   localparam int unsigned POS_OFF_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
   localparam logic [7:0] CTRL_B_RESET = 8'h00;
   localparam logic [7:0] INPUT_OFF_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Event mode encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_TOGGLE = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_FALLING = 2'h2;
   localparam logic [1:0] MODE_RISING = 2'h3;

   // ----------------------------------------------------------------
   // Timing: synchroniser depth in core_clk cycles
   // ----------------------------------------------------------------
   localparam int unsigned SYNC_STAGES = 2;

endpackage

// ### rtl/ce_sync.sv
// Multi-bit level synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module ce_sync #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned STAGES = ce_pkg::SYNC_STAGES
) (
   input wire logic core_clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [WIDTH-1:0] async_in, // Level from another domain
   output logic [WIDTH-1:0] sync_out // Level safe to use here
);

   logic [WIDTH-1:0] stage_reg [STAGES];

   // Depth below two gives no metastability margin; refused at elaboration
   if (STAGES < 2 || WIDTH < 1)
   begin
      $error("ce_sync: STAGES must be at least 2 and WIDTH at least 1");
   end

   // Shift chain; only the next stage reads each flop but the last, which drives sync_out
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < STAGES; i++)
            stage_reg[i] <= '0;
      end
      else
      begin
         stage_reg[0] <= async_in;
         for (int i = 1; i < STAGES; i++)
            stage_reg[i] <= stage_reg[i-1];
      end
   end

   assign sync_out = stage_reg[STAGES-1];

endmodule

// ### tb/ce_analog_model.sv
// Behavioural model of the analog comparator core and the timer capture unit
`timescale 1ns/1ps
module ce_analog_model #(
   parameter logic [7:0] BANDGAP_LEVEL = 8'h70 // Reference level, arbitrary
) (
   input wire logic core_clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [7:0] positive_level, // Positive pin voltage
   input wire logic [7:0] negative_level, // Negative pin voltage
   input wire logic comparator_power_down, // Core power off
   input wire logic positive_bandgap_select, // Bandgap on positive input
   input wire logic negative_mux_select, // Channel on negative input
   input wire logic [2:0] negative_channel, // Channel number
   input wire logic capture_trigger, // Capture front end input
   input wire logic timer_capture_irq_enable, // Timer capture interrupt enable
   output logic comparator_raw, // Decision to the block
   output logic [7:0] capture_count, // Rising edges captured
   output logic capture_irq // Timer capture interrupt
);
   logic [7:0] pos_in;
   logic [7:0] neg_in;
   logic trig_q;
   logic wobble;
   // Input selection; channel n sits at n times 0x20
   assign pos_in = positive_bandgap_select ? BANDGAP_LEVEL : positive_level;
   assign neg_in = negative_mux_select ? {negative_channel, 5'h00} : negative_level;
   // A powered-down core has no valid decision, so it wobbles instead of holding
   assign comparator_raw = comparator_power_down ? wobble : (pos_in > neg_in);
   // Capture edge counting; its interrupt needs the timer's own enable
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wobble <= 1'b0;
         trig_q <= 1'b0;
         capture_irq <= 1'b0;
         capture_count <= 8'h00;
      end
      else
      begin
         wobble <= ~wobble;
         trig_q <= capture_trigger;
         capture_irq <= (capture_trigger === 1'b1) && (trig_q === 1'b0)
                        && timer_capture_irq_enable;
         if ((capture_trigger === 1'b1) && (trig_q === 1'b0))
            capture_count <= capture_count + 8'h01;
      end
   end
endmodule

// ### tb/comparator_event_control_tb.sv
// Self-checking bench for the comparator event control block
`timescale 1ns/1ps
module comparator_event_control_tb;
   logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, comparator_raw;
   logic [7:0] avs_address, pos_lv, neg_lv, cap_cnt;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic comparator_power_down, positive_bandgap_select, negative_mux_select, converter_enable;
   logic [2:0] negative_channel, channel_select;
   logic global_irq_enable, irq_vector_taken, comparator_irq, capture_trigger, cap_ie;
   logic positive_pin_raw, negative_pin_raw, positive_pin_input_off, negative_pin_input_off;
   logic positive_pin_read, negative_pin_read;
   int miscompares = 0;
   int n_tests = 0;
   localparam logic [7:0] CS = ce_pkg::CTRL_STATUS_OFFSET;
   localparam logic [7:0] CB = ce_pkg::CTRL_B_OFFSET;
   localparam logic [7:0] IO = ce_pkg::INPUT_OFF_OFFSET;

   ce_event_ctrl uut (
      .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .comparator_raw,
      .comparator_power_down, .positive_bandgap_select, .negative_mux_select,
      .negative_channel, .converter_enable, .channel_select, .global_irq_enable,
      .irq_vector_taken, .comparator_irq, .capture_trigger, .positive_pin_raw,
      .negative_pin_raw, .positive_pin_input_off, .negative_pin_input_off,
      .positive_pin_read, .negative_pin_read
   );
   ce_analog_model partner (
      .core_clk, .sys_rst, .positive_level(pos_lv), .negative_level(neg_lv),
      .comparator_power_down,
      .positive_bandgap_select, .negative_mux_select, .negative_channel, .capture_trigger,
      .timer_capture_irq_enable(cap_ie), .comparator_raw, .capture_count(cap_cnt),
      .capture_irq()
   );

   // ------------------------------------------------------------
   // Bus and checking tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (miscompares == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; a hung slave ends the run
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++)
         @(posedge core_clk);
      if (i == 20)
      begin
         miscompares++;
         report_and_stop();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      access(1'b0, a, 8'h00);
      check(avs_readdata[7:0], exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Positive pin level change, then time for sync, flag and interrupt
   task automatic lvl(input logic [7:0] p);
      pos_lv <= p;
      tick(6);
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      {avs_read, avs_write, converter_enable, irq_vector_taken} = 4'h0;
      {global_irq_enable, cap_ie, positive_pin_raw, negative_pin_raw} = 4'hF;
      avs_address = 8'h00;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      channel_select = 3'h0;
      pos_lv = 8'h0A;
      neg_lv = 8'h14;
      tick(16);
      sys_rst <= 1'b0;
      rd(CS, 8'h00);
      rd(CB, 8'h00);
      access(1'b1, 8'h3C, 8'hFF);
      rd(8'h3C, 8'h00);
      lvl(8'h30);
      rd(CS, 8'h30);
      access(1'b1, CS, 8'h10);
      rd(CS, 8'h20);
      // Toggle event; a zero flag bit keeps it, reserved mode blocks a new one
      lvl(8'h00);
      access(1'b1, CS, 8'h41);
      tick(4);
      check(8'(positive_bandgap_select), 8'h01);
      rd(CS, 8'h71);
      access(1'b1, CS, 8'h00);
      tick(4);
      access(1'b1, CS, 8'h90);
      check(8'(comparator_power_down), 8'h00);
      tick(2);
      check(8'(comparator_power_down), 8'h01);
      rd(CS, 8'h80);
      access(1'b1, CS, 8'h10);
      tick(6);
      // Every mode against one rising and one falling edge
      for (int k = 0; k < 4; k++)
      begin
         access(1'b1, CS, 8'h10 | 8'(k));
         lvl(8'h30);
         rd(CS, 8'h20 | 8'(k) | ((k == 0 || k == 3) ? 8'h10 : 8'h00));
         access(1'b1, CS, 8'h10 | 8'(k));
         lvl(8'h00);
         rd(CS, 8'(k) | ((k == 0 || k == 2) ? 8'h10 : 8'h00));
      end
      // Interrupt: 4 edges from raw change, gated by global enable, cleared by vector
      access(1'b1, CS, 8'h0B);
      pos_lv <= 8'h30;
      tick(4);
      check(8'(comparator_irq), 8'h00);
      tick(1);
      check(8'(comparator_irq), 8'h01);
      global_irq_enable <= 1'b0;
      tick(2);
      check(8'(comparator_irq), 8'h00);
      global_irq_enable <= 1'b1;
      tick(2);
      check(8'(comparator_irq), 8'h01);
      irq_vector_taken <= 1'b1;
      tick(1);
      irq_vector_taken <= 1'b0;
      tick(2);
      check(8'(comparator_irq), 8'h00);
      rd(CS, 8'h2B);
      // Capture route on, then off
      access(1'b1, CS, 8'h07);
      tick(2);
      check(8'(capture_trigger), 8'h01);
      lvl(8'h00);
      check(8'(capture_trigger), 8'h00);
      lvl(8'h30);
      check(cap_cnt, 8'h02);
      access(1'b1, CS, 8'h03);
      lvl(8'h00);
      lvl(8'h30);
      check(cap_cnt, 8'h02);
      // Borrowed channel 7 as negative input, then converter takes it back
      access(1'b1, CS, 8'h13);
      access(1'b1, CB, 8'h40);
      channel_select <= 3'h7;
      tick(6);
      check(8'({negative_mux_select, negative_channel}), 8'h0F);
      rd(CS, 8'h03);
      converter_enable <= 1'b1;
      tick(6);
      check(8'(negative_mux_select), 8'h00);
      rd(CS, 8'h33);
      // Pin buffers off force the read bits to zero
      check(8'({positive_pin_read, negative_pin_read}), 8'h03);
      access(1'b1, IO, 8'h03);
      tick(3);
      check(8'({positive_pin_input_off, negative_pin_input_off,
                positive_pin_read, negative_pin_read}), 8'h0C);
      rd(IO, 8'h03);
      report_and_stop();
   end
endmodule
